// ---- bench/teletext_i2c_command_port_test.sv ----
`timescale 1ns/10ps
`default_nettype none

module teletext_i2c_command_port_test;

   logic                 clk;
   logic                 link_clk;
   logic                 rst_b;
   logic                 tx_load;
   logic [7:0]           tx_data;
   logic                 scl;
   logic                 sda_m;
   logic                 sda_w;
   logic                 sda_o0;
   logic                 sda_o1;
   logic                 oe0_b;
   logic                 oe1_b;
   logic                 cv0;
   logic                 cv1;
   logic                 rd_done;
   logic                 rd_acked;
   ttc_pkg::ttc_cmd_type cmd0;
   ttc_pkg::ttc_cmd_type cmd1;
   ttc_pkg::ttc_cmd_type last0;
   ttc_pkg::ttc_cmd_type last1;
   logic                 last_acked;
   int                   n_cmd0;
   int                   n_cmd1;
   int                   n_rd;
   int                   err_total;
   int                   n_compared;

   // open-drain line with pull-up, low if any party pulls
   assign sda_w = sda_m & (oe0_b | sda_o0) & (oe1_b | sda_o1);

   // core clock and an unrelated link clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      link_clk = 1'b0;
      #5;
      forever #16 link_clk = ~link_clk;
   end

   // first address variant and second address variant on one bus
   ttc_cmd_port #(.VARIANT(1'b0)) ttc_cmd_port_i (
      .clk(clk), .rst_b(rst_b), .link_clk(link_clk), .scl_i(scl), .sda_i(sda_w),
      .sda_o(sda_o0), .sda_oe_b(oe0_b), .cmd_valid(cv0), .cmd(cmd0), .tx_load(tx_load),
      .tx_data(tx_data), .rd_done(rd_done), .rd_acked(rd_acked));
   ttc_cmd_port #(.VARIANT(1'b1)) ttc_cmd_port_1_i (
      .clk(clk), .rst_b(rst_b), .link_clk(link_clk), .scl_i(scl), .sda_i(sda_w),
      .sda_o(sda_o1), .sda_oe_b(oe1_b), .cmd_valid(cv1), .cmd(cmd1), .tx_load(tx_load),
      .tx_data(tx_data), .rd_done(), .rd_acked());
   ttc_host_model ttc_host_model_i (
      .link_clk(link_clk), .sda(sda_w), .scl(scl), .sda_m(sda_m));

   // counts and captures every delivery pulse, mid-cycle where outputs are settled
   always @(negedge clk) begin
      if (cv0 === 1'b1) begin
         n_cmd0++;
         last0 = cmd0;
      end
      if (cv1 === 1'b1) begin
         n_cmd1++;
         last1 = cmd1;
      end
      if (rd_done === 1'b1) begin
         n_rd++;
         last_acked = rd_acked;
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic print_verdict();
      if (err_total == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : print_verdict

   // write frame of n bytes, ack of each slot compared
   task automatic wr(input logic [7:0] adr, input logic [23:0] d, input int n,
                     input logic [3:0] exp_ack);
      logic       a;
      logic [3:0] got;
      got = 4'h0;
      ttc_host_model_i.start_cond();
      ttc_host_model_i.send_byte(adr, a);
      got[0] = a;
      for (int i = 0; i < n; i++) begin
         ttc_host_model_i.send_byte(d[23-8*i -: 8], a);
         got[i+1] = a;
      end
      ttc_host_model_i.stop_cond();
      check({28'h0, got}, {28'h0, exp_ack});
      repeat (60) @(posedge clk);
   endtask : wr

   // two back-to-back user commands at the edge values
   task automatic t_user();
      int c0;
      c0 = n_cmd0;
      wr(8'h58, 24'h000000, 1, 4'h3);
      wr(8'h58, 24'hff0000, 1, 4'h3);
      check(n_cmd0 - c0, 32'h2);
      check({15'h0, last0}, {15'h0, 1'b0, 8'hff, 8'h00});
   endtask : t_user

   // system command to the second address only
   task automatic t_system();
      int c0;
      int c1;
      c0 = n_cmd0;
      c1 = n_cmd1;
      wr(8'h60, 24'h3cc300, 2, 4'h7);
      check(n_cmd1 - c1, 32'h1);
      check({15'h0, last1}, {15'h0, 1'b1, 8'h3c, 8'hc3});
      check(n_cmd0 - c0, 32'h0);
   endtask : t_system

   // foreign address and an overlong write deliver nothing
   task automatic t_refuse();
      int c0;
      int c1;
      c0 = n_cmd0;
      c1 = n_cmd1;
      wr(8'h42, 24'h5a0000, 1, 4'h0);
      wr(8'h58, 24'h112233, 3, 4'h7);
      check((n_cmd0 - c0) + (n_cmd1 - c1), 32'h0);
   endtask : t_refuse

   // loaded byte read twice, once acked and once refused
   task automatic t_read();
      logic [7:0] v;
      logic       a;
      int         r0;
      r0 = n_rd;
      @(posedge clk);
      tx_load <= 1'b1;
      tx_data <= 8'h96;
      @(posedge clk);
      tx_load <= 1'b0;
      for (int k = 0; k < 2; k++) begin
         ttc_host_model_i.start_cond();
         ttc_host_model_i.send_byte(8'h59, a);
         check({31'h0, a}, 32'h1);
         ttc_host_model_i.recv_byte(k == 0, v);
         ttc_host_model_i.stop_cond();
         repeat (60) @(posedge clk);
         check({24'h0, v}, 32'h96);
         check({31'h0, last_acked}, {31'h0, k == 0});
      end
      check(n_rd - r0, 32'h2);
   endtask : t_read

   // main sequence
   initial begin
      rst_b      = 1'b0;
      tx_load    = 1'b0;
      tx_data    = 8'h00;
      n_cmd0     = 0;
      n_cmd1     = 0;
      n_rd       = 0;
      err_total  = 0;
      n_compared = 0;
      last_acked = 1'b0;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      repeat (40) @(posedge clk);
      t_user();
      t_system();
      t_refuse();
      t_read();
      print_verdict();
   end

   // watchdog about three times the expected run of some 135 us
   initial begin
      #400000;
      err_total++;
      print_verdict();
   end

endmodule : teletext_i2c_command_port_test

`default_nettype wire

// ---- bench/ttc_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none

// serial bus master that drives the command port from the host side
module ttc_host_model (
   input  wire logic link_clk,  // pacing clock for bus phases
   input  wire logic sda,       // resolved data line
   output logic      scl,       // serial clock, idles high
   output logic      sda_m      // master data drive, 1 = released
);

   // both lines released before the first frame
   initial begin
      scl   = 1'b1;
      sda_m = 1'b1;
   end

   // one bus phase, well above the slave's sampling latency
   task automatic pause();
      repeat (8) @(posedge link_clk);
   endtask : pause

   // data falls while the clock is high
   task automatic start_cond();
      sda_m <= 1'b1;
      scl   <= 1'b1;
      pause();
      sda_m <= 1'b0;
      pause();
      scl   <= 1'b0;
      pause();
   endtask : start_cond

   // data rises while the clock is high
   task automatic stop_cond();
      sda_m <= 1'b0;
      pause();
      scl   <= 1'b1;
      pause();
      sda_m <= 1'b1;
      pause();
   endtask : stop_cond

   // one clock pulse, data set while low and sampled at the end of the high phase
   task automatic clock_bit(input logic b, output logic seen);
      sda_m <= b;
      pause();
      scl   <= 1'b1;
      pause();
      seen = sda;
      scl  <= 1'b0;
      pause();
   endtask : clock_bit

   // msb first, then a released ack slot read back
   task automatic send_byte(input logic [7:0] v, output logic acked);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clock_bit(v[i], s);
      end
      clock_bit(1'b1, s);
      acked = ~s;
   endtask : send_byte

   // reads eight bits, then acks or leaves the slot released
   task automatic recv_byte(input logic give_ack, output logic [7:0] v);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clock_bit(1'b1, s);
         v[i] = s;
      end
      clock_bit(~give_ack, s);
   endtask : recv_byte

endmodule : ttc_host_model

`default_nettype wire

// ---- verilog/ttc_cmd_port.sv ----
`timescale 1ns/10ps
`default_nettype none

// Operation
// - The block is a serial-bus target through which the host hands commands in and reads data out.
// - A user command is start, write address, ack, one command byte, ack, stop.
// - A system command is start, write address, ack, command byte, ack, parameter byte, ack, stop.
// - A user read is start, read address, ack, one data byte from the block, master ack, stop.
// - The block answers only at its variant address, 58H for the first and 60H for the second.
module ttc_cmd_port #(
   parameter bit VARIANT = 1'b0                   // 0 selects the first address, 1 the second
) (
   input  wire logic                 clk,         // core clock, 125 MHz
   input  wire logic                 rst_b,       // async reset, active low
   input  wire logic                 link_clk,    // oversampling clock of the serial link
   input  wire logic                 scl_i,       // serial clock pin level
   input  wire logic                 sda_i,       // serial data pin level
   output logic                      sda_o,       // serial data drive value, always low
   output logic                      sda_oe_b,    // low while pulling the data line low
   output logic                      cmd_valid,   // one-cycle pulse, new command
   output ttc_pkg::ttc_cmd_type      cmd,         // command fields, held until the next
   input  wire logic                 tx_load,     // one-cycle strobe, new read byte
   input  wire logic [7:0]           tx_data,     // byte returned by the next user read
   output logic                      rd_done,     // one-cycle pulse, user read finished
   output logic                      rd_acked     // master acked the read byte
);

   localparam logic [7:0] DEV_ADDR = VARIANT ? ttc_pkg::ADDR_VAR1 : ttc_pkg::ADDR_VAR0;

   // link domain signals
   logic                    scl_s;
   logic                    sda_s;
   logic                    scl_prev_q;
   logic                    sda_prev_q;
   logic                    start_w;
   logic                    stop_w;
   logic                    scl_rise_w;
   logic                    scl_fall_w;
   ttc_pkg::ttc_state_type  state_q;
   ttc_pkg::ttc_state_type  state_d;
   logic [3:0]              bcnt_q;
   logic [7:0]              shift_q;
   logic [7:0]              tx_q;
   logic [1:0]              nbytes_q;
   logic                    rw_q;
   logic                    sda_oe_b_q;
   ttc_pkg::ttc_cmd_type    cmd_hold_q;
   logic                    deliver_w;
   logic                    addr_hit_w;
   logic                    rd_end_q;
   logic                    rd_ack_q;
   logic [7:0]              tx_word;

   // pins pass two flops in the link domain, reset to the idle high level
   ttc_sync #(.WIDTH(2), .RST_VAL(1'b1)) u_pin_sync (
      .clk   (link_clk),
      .rst_b (rst_b),
      .d     ({scl_i, sda_i}),
      .q     ({scl_s, sda_s})
   );

   // previous synchronised levels for edge detection
   always_ff @(posedge link_clk or negedge rst_b) begin
      if (!rst_b) begin
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end else begin
         scl_prev_q <= scl_s;
         sda_prev_q <= sda_s;
      end
   end

   // bus conditions: start and stop are data edges while the clock is high
   assign start_w    = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
   assign stop_w     = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
   assign scl_rise_w = scl_s & ~scl_prev_q;
   assign scl_fall_w = ~scl_s & scl_prev_q;

   // address match ignores the direction bit
   assign addr_hit_w = (shift_q[7:1] == DEV_ADDR[7:1]);

   // a write ends cleanly after one or two whole bytes; the stop's clock rise counts one bit
   assign deliver_w = stop_w && (state_q == ttc_pkg::ST_WR_DATA)
                      && (bcnt_q == ttc_pkg::BIT_ONE)
                      && (nbytes_q != ttc_pkg::NB_NONE);

   // next state of the serial engine
   always_comb begin
      state_d = state_q;
      if (start_w) begin
         state_d = ttc_pkg::ST_ADDR;
      end else if (stop_w) begin
         state_d = ttc_pkg::ST_IDLE;
      end else begin
         case (state_q)
            ttc_pkg::ST_ADDR: begin
               if (scl_fall_w && bcnt_q == ttc_pkg::BIT_LAST) begin
                  state_d = addr_hit_w ? ttc_pkg::ST_ADDR_AK : ttc_pkg::ST_IGNORE;
               end
            end
            ttc_pkg::ST_ADDR_AK: begin
               if (scl_fall_w) begin
                  state_d = rw_q ? ttc_pkg::ST_RD_DATA : ttc_pkg::ST_WR_DATA;
               end
            end
            ttc_pkg::ST_WR_DATA: begin
               if (scl_fall_w && bcnt_q == ttc_pkg::BIT_LAST) begin
                  // a third byte is refused and the transfer dropped
                  state_d = (nbytes_q == ttc_pkg::NB_SYSTEM) ? ttc_pkg::ST_IGNORE
                                                             : ttc_pkg::ST_WR_AK;
               end
            end
            ttc_pkg::ST_WR_AK: begin
               if (scl_fall_w) begin
                  state_d = ttc_pkg::ST_WR_DATA;
               end
            end
            ttc_pkg::ST_RD_DATA: begin
               if (scl_fall_w && bcnt_q == ttc_pkg::BIT_LAST) begin
                  state_d = ttc_pkg::ST_RD_AK;
               end
            end
            ttc_pkg::ST_RD_AK: begin
               if (scl_rise_w) begin
                  state_d = ttc_pkg::ST_IGNORE;
               end
            end
            ttc_pkg::ST_IDLE,
            ttc_pkg::ST_IGNORE: begin
               state_d = state_q;
            end
            default: begin
               state_d = ttc_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // state register
   always_ff @(posedge link_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= ttc_pkg::ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // bit counter and receive shifter
   always_ff @(posedge link_clk or negedge rst_b) begin
      if (!rst_b) begin
         bcnt_q  <= ttc_pkg::BIT_FIRST;
         shift_q <= ttc_pkg::BYTE_ZERO;
      end else if (start_w) begin
         bcnt_q  <= ttc_pkg::BIT_FIRST;
      end else if ((state_q == ttc_pkg::ST_ADDR || state_q == ttc_pkg::ST_WR_DATA)
                   && scl_rise_w && bcnt_q != ttc_pkg::BIT_LAST) begin
         shift_q <= {shift_q[6:0], sda_s};
         bcnt_q  <= bcnt_q + ttc_pkg::BIT_ONE;
      end else if (state_q == ttc_pkg::ST_ADDR_AK && scl_fall_w) begin
         bcnt_q  <= rw_q ? ttc_pkg::BIT_ONE : ttc_pkg::BIT_FIRST;
      end else if (state_q == ttc_pkg::ST_WR_AK && scl_fall_w) begin
         bcnt_q  <= ttc_pkg::BIT_FIRST;
      end else if (state_q == ttc_pkg::ST_RD_DATA && scl_fall_w
                   && bcnt_q != ttc_pkg::BIT_LAST) begin
         bcnt_q  <= bcnt_q + ttc_pkg::BIT_ONE;
      end
   end

   // direction bit and byte count of the current transfer
   always_ff @(posedge link_clk or negedge rst_b) begin
      if (!rst_b) begin
         rw_q     <= 1'b0;
         nbytes_q <= ttc_pkg::NB_NONE;
      end else if (start_w) begin
         nbytes_q <= ttc_pkg::NB_NONE;
      end else if (state_q == ttc_pkg::ST_ADDR && scl_fall_w && bcnt_q == ttc_pkg::BIT_LAST) begin
         rw_q     <= shift_q[ttc_pkg::RW_BIT];
      end else if (state_q == ttc_pkg::ST_WR_DATA && scl_fall_w
                   && bcnt_q == ttc_pkg::BIT_LAST && nbytes_q != ttc_pkg::NB_SYSTEM) begin
         nbytes_q <= nbytes_q + ttc_pkg::NB_USER;
      end
   end

   // command capture: first byte is the command, second the parameter
   always_ff @(posedge link_clk or negedge rst_b) begin
      if (!rst_b) begin
         cmd_hold_q <= '0;
      end else if (state_q == ttc_pkg::ST_WR_DATA && scl_fall_w && bcnt_q == ttc_pkg::BIT_LAST) begin
         if (nbytes_q == ttc_pkg::NB_NONE) begin
            cmd_hold_q.command <= shift_q;
            cmd_hold_q.param   <= ttc_pkg::BYTE_ZERO;
            cmd_hold_q.kind    <= ttc_pkg::CMD_USER;
         end else if (nbytes_q == ttc_pkg::NB_USER) begin
            cmd_hold_q.param   <= shift_q;
            cmd_hold_q.kind    <= ttc_pkg::CMD_SYSTEM;
         end
      end
   end

   // read byte: loaded at the address ack, shifted out on each falling edge
   always_ff @(posedge link_clk or negedge rst_b) begin
      if (!rst_b) begin
         tx_q <= ttc_pkg::BYTE_ZERO;
      end else if (state_q == ttc_pkg::ST_ADDR_AK && scl_fall_w && rw_q) begin
         tx_q <= {tx_word[6:0], 1'b0};
      end else if (state_q == ttc_pkg::ST_RD_DATA && scl_fall_w) begin
         tx_q <= {tx_q[6:0], 1'b0};
      end
   end

   // open-drain data drive: ack slots and zero read bits pull low
   always_ff @(posedge link_clk or negedge rst_b) begin
      if (!rst_b) begin
         sda_oe_b_q <= 1'b1;
      end else if (start_w || stop_w) begin
         sda_oe_b_q <= 1'b1;
      end else if (scl_fall_w) begin
         case (state_q)
            ttc_pkg::ST_ADDR: begin
               sda_oe_b_q <= !(bcnt_q == ttc_pkg::BIT_LAST && addr_hit_w);
            end
            ttc_pkg::ST_ADDR_AK: begin
               sda_oe_b_q <= rw_q ? tx_word[7] : 1'b1;
            end
            ttc_pkg::ST_WR_DATA: begin
               sda_oe_b_q <= !(bcnt_q == ttc_pkg::BIT_LAST
                               && nbytes_q != ttc_pkg::NB_SYSTEM);
            end
            ttc_pkg::ST_RD_DATA: begin
               sda_oe_b_q <= (bcnt_q == ttc_pkg::BIT_LAST) ? 1'b1 : tx_q[7];
            end
            default: begin
               sda_oe_b_q <= 1'b1;
            end
         endcase
      end
   end

   // read end event with the master's acknowledge
   always_ff @(posedge link_clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_end_q <= 1'b0;
         rd_ack_q <= 1'b0;
      end else begin
         rd_end_q <= (state_q == ttc_pkg::ST_RD_AK) && scl_rise_w && !start_w && !stop_w;
         if (state_q == ttc_pkg::ST_RD_AK && scl_rise_w) begin
            rd_ack_q <= ~sda_s;
         end
      end
   end

   assign sda_o    = 1'b0;
   assign sda_oe_b = sda_oe_b_q;

   // finished commands cross to the core clock
   ttc_xfer #(.WIDTH(ttc_pkg::CMD_W)) u_cmd_xfer (
      .src_clk   (link_clk),
      .src_rst_b (rst_b),
      .src_valid (deliver_w),
      .src_data  (cmd_hold_q),
      .dst_clk   (clk),
      .dst_rst_b (rst_b),
      .dst_valid (cmd_valid),
      .dst_data  (cmd)
   );

   // read byte crosses from the core clock to the link
   ttc_xfer #(.WIDTH(ttc_pkg::BYTE_W)) u_tx_xfer (
      .src_clk   (clk),
      .src_rst_b (rst_b),
      .src_valid (tx_load),
      .src_data  (tx_data),
      .dst_clk   (link_clk),
      .dst_rst_b (rst_b),
      .dst_valid (),
      .dst_data  (tx_word)
   );

   // read completion crosses back to the core clock
   ttc_xfer #(.WIDTH(1)) u_rd_xfer (
      .src_clk   (link_clk),
      .src_rst_b (rst_b),
      .src_valid (rd_end_q),
      .src_data  (rd_ack_q),
      .dst_clk   (clk),
      .dst_rst_b (rst_b),
      .dst_valid (rd_done),
      .dst_data  (rd_acked)
   );

   // checks on the serial engine
   a_addr_ack_drive: assert property (@(posedge link_clk) disable iff (!rst_b)
      (state_q == ttc_pkg::ST_ADDR && scl_fall_w && bcnt_q == ttc_pkg::BIT_LAST
       && addr_hit_w && !start_w && !stop_w) |=> (!sda_oe_b && state_q == ttc_pkg::ST_ADDR_AK))
      else $error("matching address not acknowledged");

   a_foreign_released: assert property (@(posedge link_clk) disable iff (!rst_b)
      (state_q == ttc_pkg::ST_ADDR && scl_fall_w && bcnt_q == ttc_pkg::BIT_LAST
       && !addr_hit_w && !start_w && !stop_w)
      |=> (sda_oe_b throughout (state_q == ttc_pkg::ST_IGNORE)[*3]) or
          (state_q != ttc_pkg::ST_IGNORE))
      else $error("data line driven during foreign transfer");
   a_ignore_released: assert property (@(posedge link_clk) disable iff (!rst_b)
      (state_q == ttc_pkg::ST_IGNORE) |-> sda_oe_b)
      else $error("data line driven while ignoring the bus");

   a_user_cmd_kind: assert property (@(posedge link_clk) disable iff (!rst_b)
      (deliver_w && nbytes_q == ttc_pkg::NB_USER)
      |-> (cmd_hold_q.kind == ttc_pkg::CMD_USER && cmd_hold_q.param == ttc_pkg::BYTE_ZERO))
      else $error("one-byte write not delivered as user command");

   a_sys_cmd_kind: assert property (@(posedge link_clk) disable iff (!rst_b)
      (deliver_w && nbytes_q == ttc_pkg::NB_SYSTEM) |-> cmd_hold_q.kind == ttc_pkg::CMD_SYSTEM)
      else $error("two-byte write not delivered as system command");

   a_read_first_bit: assert property (@(posedge link_clk) disable iff (!rst_b)
      (state_q == ttc_pkg::ST_ADDR_AK && scl_fall_w && rw_q && !start_w && !stop_w)
      |=> (sda_oe_b == $past(tx_word[7]) && state_q == ttc_pkg::ST_RD_DATA))
      else $error("first read bit not driven after address ack");

   a_cmd_one_pulse: assert property (@(posedge clk) disable iff (!rst_b)
      cmd_valid |=> !cmd_valid)
      else $error("command strobe longer than one cycle");

   c_user_cmd: cover property (@(posedge link_clk) disable iff (!rst_b)
      deliver_w && nbytes_q == ttc_pkg::NB_USER);
   c_sys_cmd: cover property (@(posedge link_clk) disable iff (!rst_b)
      deliver_w && nbytes_q == ttc_pkg::NB_SYSTEM);
   c_user_read: cover property (@(posedge clk) disable iff (!rst_b) rd_done && rd_acked);
   c_foreign: cover property (@(posedge link_clk) disable iff (!rst_b)
      state_q == ttc_pkg::ST_IGNORE && stop_w);

endmodule : ttc_cmd_port

`default_nettype wire

// ---- verilog/ttc_pkg.sv ----
package ttc_pkg;

   // byte geometry on the serial line
   localparam int unsigned BYTE_W     = 8;
   localparam logic [3:0]  BIT_LAST   = 4'h8;     // bits counted before the ack slot
   localparam logic [3:0]  BIT_FIRST  = 4'h0;
   localparam logic [3:0]  BIT_ONE    = 4'h1;     // first read bit already on the line
   localparam logic [1:0]  NB_NONE    = 2'h0;
   localparam logic [1:0]  NB_USER    = 2'h1;     // one byte: plain command
   localparam logic [1:0]  NB_SYSTEM  = 2'h2;     // two bytes: command and parameter

   // fixed target addresses, eight-bit form with write direction bit clear
   localparam logic [7:0]  ADDR_VAR0  = 8'h58;
   localparam logic [7:0]  ADDR_VAR1  = 8'h60;
   localparam int unsigned RW_BIT     = 0;        // direction bit position in address byte
   localparam logic [7:0]  BYTE_ZERO  = 8'h00;
   localparam logic [7:0]  TX_RESET   = 8'hff;    // unused; the read byte resets to 00H before software loads any

   // kinds of command handed to the decoder core
   typedef enum logic {
      CMD_USER   = 1'b0,
      CMD_SYSTEM = 1'b1
   } ttc_kind_type;

   // one finished write transfer
   typedef struct packed {
      ttc_kind_type     kind;
      logic [7:0]       command;
      logic [7:0]       param;
   } ttc_cmd_type;

   localparam int unsigned CMD_W = $bits(ttc_cmd_type);

   // serial engine states
   typedef enum logic [2:0] {
      ST_IDLE    = 3'b000,
      ST_ADDR    = 3'b001,
      ST_ADDR_AK = 3'b010,
      ST_WR_DATA = 3'b011,
      ST_WR_AK   = 3'b100,
      ST_RD_DATA = 3'b101,
      ST_RD_AK   = 3'b110,
      ST_IGNORE  = 3'b111
   } ttc_state_type;

endpackage : ttc_pkg

// ---- verilog/ttc_sync.sv ----
`timescale 1ns/10ps
`default_nettype none

module ttc_sync #(
   parameter int unsigned WIDTH   = 1,
   parameter logic        RST_VAL = 1'b0   // level held through reset
) (
   input  wire logic             clk,     // destination clock
   input  wire logic             rst_b,   // async reset, active low
   input  wire logic [WIDTH-1:0] d,       // asynchronous levels
   output logic      [WIDTH-1:0] q        // synchronised levels
);

   // two flops per bit, first stage read only by the second
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         logic meta_q;
         logic sync_q;
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               meta_q <= RST_VAL;
               sync_q <= RST_VAL;
            end else begin
               meta_q <= d[i];
               sync_q <= meta_q;
            end
         end
         assign q[i] = sync_q;
      end
   endgenerate

endmodule : ttc_sync

`default_nettype wire

// ---- verilog/ttc_xfer.sv ----
`timescale 1ns/10ps
`default_nettype none

module ttc_xfer #(
   parameter int unsigned WIDTH = 8
) (
   input  wire logic             src_clk,    // sending clock
   input  wire logic             src_rst_b,  // async reset, sending side
   input  wire logic             src_valid,  // one-cycle word strobe
   input  wire logic [WIDTH-1:0] src_data,   // word with the strobe
   input  wire logic             dst_clk,    // receiving clock
   input  wire logic             dst_rst_b,  // async reset, receiving side
   output logic                  dst_valid,  // one-cycle pulse on arrival
   output logic      [WIDTH-1:0] dst_data    // word, held until the next
);

   logic             tgl_q;
   logic [WIDTH-1:0] hold_q;
   logic             tgl_s;
   logic             tgl_seen_q;
   logic [WIDTH-1:0] dst_data_q;
   logic             dst_valid_q;

   // sending side: hold the word and flip the toggle
   always_ff @(posedge src_clk or negedge src_rst_b) begin
      if (!src_rst_b) begin
         tgl_q  <= 1'b0;
         hold_q <= '0;
      end else if (src_valid) begin
         tgl_q  <= ~tgl_q;
         hold_q <= src_data;
      end
   end

   ttc_sync #(.WIDTH(1)) u_sync (
      .clk   (dst_clk),
      .rst_b (dst_rst_b),
      .d     (tgl_q),
      .q     (tgl_s)
   );

   // receiving side: a toggle change means the held word is stable
   always_ff @(posedge dst_clk or negedge dst_rst_b) begin
      if (!dst_rst_b) begin
         tgl_seen_q  <= 1'b0;
         dst_valid_q <= 1'b0;
         dst_data_q  <= '0;
      end else begin
         tgl_seen_q  <= tgl_s;
         dst_valid_q <= tgl_s ^ tgl_seen_q;
         if (tgl_s ^ tgl_seen_q) begin
            dst_data_q <= hold_q;
         end
      end
   end

   assign dst_valid = dst_valid_q;
   assign dst_data  = dst_data_q;

endmodule : ttc_xfer

`default_nettype wire
